// file: core/pll_loop_control_registers.v
// register bank holding loop filter, pump and feedback divider settings
// assumes an avalon-mm master on sys_clk; fields drive the analog loop
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`include "loop_ctrl_defs.vh"

// What this block does
// R1: zero-resistor register low four bits select loop zero resistance or external.
// R2: pump current register holds an eight-bit magnitude code for the output loop.
// R3: feedback register holds A in bits 7:6, B in 5:0; divide is 4B+A.
// R4: software programs only permitted A/B pairs, ratios up to 255.
// R5: control bit 7 set powers down the output loop lock detector.
// R6: software keeps control bit 6 at zero, its default.
// R7: control bit 5 set doubles the output loop reference frequency.
// R8: override bit clear applies high antibacklash width, ignoring the field.
// R9: override bit rising from zero to one forces the width field to 00.
// R10: with override set, width field selects minimum, low, high or maximum.
// R11: software is advised to set override and leave width at minimum.
// R12: pump mode field selects tristate, up, down or normal; default normal.
// R13: reserved bits read as zero and ignore writes.
module pll_loop_control_registers (
  input  wire                 sys_clk,
  input  wire                 rst,
  input  wire                 clk_en,
  input  wire [`ADDR_W-1:0]   avs_address,
  input  wire                 avs_read,
  input  wire                 avs_write,
  input  wire [31:0]          avs_writedata,
  input  wire [3:0]           avs_byteenable,
  output reg  [31:0]          avs_readdata,
  output wire                 avs_waitrequest,
  output reg  [2:0]           zero_res_sel,
  output reg                  zero_res_ext,
  output reg  [7:0]           pump_current,
  output reg  [1:0]           fb_a_count,
  output reg  [5:0]           fb_b_count,
  output reg  [7:0]           fb_ratio,
  output reg                  lock_det_pd,
  output reg                  ref_doubler_en,
  output reg  [1:0]           abl_width,
  output reg  [1:0]           pump_mode
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // byte address of a register index; bits below the word are ignored
  function hit;
    input [`ADDR_W-1:0] addr;
    input [9:0]         idx;
    begin
      hit = (addr[`ADDR_W-1:2] == idx);
    end
  endfunction

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // one wait cycle per access: the answer comes on the second edge;
  // it is also held off while clk_en is low, so the master never
  // retires a write that the frozen bank did not take
  localparam HS_IDLE   = 1'b0;
  localparam HS_ANSWER = 1'b1;

  reg        hs_r;
  reg        hs_nxt;
  wire       req;
  wire       answer;
  wire       wr_go;
  wire       rd_go;
  wire [7:0] wdat;
  wire       lane0;

  assign req             = avs_read | avs_write;
  assign answer          = (hs_r == HS_ANSWER) & clk_en;
  assign avs_waitrequest = req & ~answer;
  assign wr_go           = avs_write & answer & lane0;
  assign rd_go           = avs_read & (hs_r == HS_IDLE) & clk_en;
  assign wdat            = avs_writedata[7:0];
  assign lane0           = avs_byteenable[0];

  always @* begin
    hs_nxt = hs_r;
    case (hs_r)
      HS_IDLE: begin
        if (req) begin
          hs_nxt = HS_ANSWER;
        end
      end
      HS_ANSWER: begin
        hs_nxt = HS_IDLE;
      end
      default: begin
        hs_nxt = HS_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      hs_r <= HS_IDLE;
    end else if (clk_en) begin
      hs_r <= hs_nxt;
    end
  end

  // ------------------------------------------------------------
  // register select
  // ------------------------------------------------------------
  wire sel_zr;
  wire sel_pump;
  wire sel_fb;
  wire sel_ctl;
  wire wr_zr;
  wire wr_pump;
  wire wr_fb;
  wire wr_ctl;

  assign sel_zr   = hit(avs_address, `ZERO_RES_IDX);
  assign sel_pump = hit(avs_address, `PUMP_CUR_IDX);
  assign sel_fb   = hit(avs_address, `FB_DIV_IDX);
  assign sel_ctl  = hit(avs_address, `LOOP_CTRL_IDX);
  assign wr_zr    = wr_go & sel_zr;
  assign wr_pump  = wr_go & sel_pump;
  assign wr_fb    = wr_go & sel_fb;
  assign wr_ctl   = wr_go & sel_ctl;

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  reg [3:0] zr_r;
  reg [7:0] pump_r;
  reg [7:0] fb_r;
  reg [7:0] ctl_r;

  // upper nibble is reserved and never stored
  always @(posedge sys_clk) begin
    if (rst) begin
      zr_r <= `ZR_RST;
    end else if (wr_zr) begin
      zr_r <= wdat[`ZR_CODE_MSB:0];                      // see R13
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      pump_r <= `PUMP_RST;
    end else if (wr_pump) begin
      pump_r <= wdat;                                    // see R2
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      fb_r <= `FB_RST;
    end else if (wr_fb) begin
      fb_r <= wdat;                                      // see R3
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  reg  [7:0] ctl_nxt;
  wire       ovr_rise;

  // leaving automatic mode clears the width field
  assign ovr_rise = ~ctl_r[`CTL_ABL_OVR] & wdat[`CTL_ABL_OVR];

  // bit 6 is reserved and always stored as zero
  always @* begin
    ctl_nxt = wdat;
    ctl_nxt[`CTL_RSVD6] = 1'b0;                          // see R13
    if (ovr_rise) begin
      ctl_nxt[`CTL_ABL_MSB:`CTL_ABL_LSB] = `ABL_MIN;     // see R9
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ctl_r <= `CTL_RST;                                 // see R12
    end else if (wr_ctl) begin
      ctl_r <= ctl_nxt;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // unmapped addresses read zero
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = `ZERO8;
    if (sel_zr) begin
      rd_byte = {`ZERO4, zr_r};                          // see R13
    end else if (sel_pump) begin
      rd_byte = pump_r;
    end else if (sel_fb) begin
      rd_byte = fb_r;
    end else if (sel_ctl) begin
      rd_byte = ctl_r;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= `ZERO32;
    end else if (rd_go) begin
      avs_readdata <= {`ZERO24, rd_byte};
    end
  end

  // ------------------------------------------------------------
  // loop outputs
  // ------------------------------------------------------------
  // registered so the analog side never sees decode glitches

  // automatic mode pins the width at high whatever the field holds
  function [1:0] abl_effective;
    input [7:0] ctl;
    begin
      if (ctl[`CTL_ABL_OVR]) begin
        abl_effective = ctl[`CTL_ABL_MSB:`CTL_ABL_LSB];  // see R10
      end else begin
        abl_effective = `ABL_HIGH;                       // see R8
      end
    end
  endfunction

  always @(posedge sys_clk) begin
    if (rst) begin
      zero_res_sel <= `ZR_SEL_883K;
    end else if (clk_en) begin
      case (zr_r)                                        // see R1
        `ZR_883K: begin
          zero_res_sel <= `ZR_SEL_883K;
        end
        `ZR_677K: begin
          zero_res_sel <= `ZR_SEL_677K;
        end
        `ZR_341K: begin
          zero_res_sel <= `ZR_SEL_341K;
        end
        `ZR_135K: begin
          zero_res_sel <= `ZR_SEL_135K;
        end
        `ZR_10K_LO,
        `ZR_10K_LM,
        `ZR_10K_HM,
        `ZR_10K_HI: begin
          zero_res_sel <= `ZR_SEL_10K;
        end
        `ZR_EXT: begin
          zero_res_sel <= `ZR_SEL_EXT;
        end
        default: begin
          // codes above 8 are undefined; they fall back to 10k
          zero_res_sel <= `ZR_SEL_10K;
        end
      endcase
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      zero_res_ext <= 1'b0;
    end else if (clk_en) begin
      zero_res_ext <= (zr_r == `ZR_EXT);                 // see R1
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      pump_current <= `PUMP_RST;
    end else if (clk_en) begin
      pump_current <= pump_r;                            // see R2
    end
  end

  // no check on A/B pairs, software owns legality; the ratio never exceeds 255
  wire [1:0] a_cnt;
  wire [5:0] b_cnt;
  wire [7:0] ratio_nxt;

  assign a_cnt     = fb_r[`FB_A_MSB:`FB_A_LSB];
  assign b_cnt     = fb_r[`FB_B_MSB:0];
  assign ratio_nxt = {b_cnt, `ZERO2} + {`ZERO6, a_cnt};  // see R3

  always @(posedge sys_clk) begin
    if (rst) begin
      fb_a_count <= `ZERO2;
    end else if (clk_en) begin
      fb_a_count <= a_cnt;                               // see R3
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      fb_b_count <= `ZERO6;
    end else if (clk_en) begin
      fb_b_count <= b_cnt;                               // see R3
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      fb_ratio <= `ZERO8;
    end else if (clk_en) begin
      fb_ratio <= ratio_nxt;                             // see R3
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      lock_det_pd <= 1'b0;
    end else if (clk_en) begin
      lock_det_pd <= ctl_r[`CTL_LD_PD];                  // see R5
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      ref_doubler_en <= 1'b0;
    end else if (clk_en) begin
      ref_doubler_en <= ctl_r[`CTL_DBL];                 // see R7
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      abl_width <= `ABL_HIGH;
    end else if (clk_en) begin
      abl_width <= abl_effective(ctl_r);                 // see R8
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      pump_mode <= `CP_NORMAL;
    end else if (clk_en) begin
      pump_mode <= ctl_r[`CTL_CP_MSB:0];                 // see R12
    end
  end

endmodule // pll_loop_control_registers

// file: core/loop_ctrl_defs.vh
// constants for the pll loop control register bank
// assumes avalon-mm byte addresses with one 32-bit word per register
`ifndef LOOP_CTRL_DEFS_VH
`define LOOP_CTRL_DEFS_VH

// ------------------------------------------------------------
// register indices; the byte address is index * 4
// ------------------------------------------------------------
`define ZERO_RES_IDX     10'h01d
`define PUMP_CUR_IDX     10'h0f0
`define FB_DIV_IDX       10'h0f1
`define LOOP_CTRL_IDX    10'h0f2
`define ADDR_W           12

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define ZR_CODE_MSB      3
`define FB_A_MSB         7
`define FB_A_LSB         6
`define FB_B_MSB         5
`define CTL_LD_PD        7
`define CTL_RSVD6        6
`define CTL_DBL          5
`define CTL_ABL_OVR      4
`define CTL_ABL_MSB      3
`define CTL_ABL_LSB      2
`define CTL_CP_MSB       1

// ------------------------------------------------------------
// encodings and reset values
// ------------------------------------------------------------
`define ZR_883K          4'h0
`define ZR_677K          4'h1
`define ZR_341K          4'h2
`define ZR_135K          4'h3
`define ZR_10K_LO        4'h4
`define ZR_10K_LM        4'h5
`define ZR_10K_HM        4'h6
`define ZR_10K_HI        4'h7
`define ZR_EXT           4'h8
`define ZR_SEL_883K      3'h0
`define ZR_SEL_677K      3'h1
`define ZR_SEL_341K      3'h2
`define ZR_SEL_135K      3'h3
`define ZR_SEL_10K       3'h4
`define ZR_SEL_EXT       3'h5
`define ABL_MIN          2'h0
`define ABL_HIGH         2'h2
`define CP_TRISTATE      2'h0
`define CP_UP            2'h1
`define CP_DOWN          2'h2
`define CP_NORMAL        2'h3
`define ZR_RST           4'h0
`define PUMP_RST         8'h00
`define FB_RST           8'h00
`define CTL_RST          8'h03
`define ZERO32           32'h00000000
`define ZERO24           24'h000000
`define ZERO8            8'h00
`define ZERO6            6'h00
`define ZERO4            4'h0
`define ZERO2            2'h0

`endif

// file: testbench/loop_ctrl_props.sv
// assertions on the loop control register bank
// sees only the bank's ports; bound from the testbench file
`timescale 1ns/10ps
`include "loop_ctrl_defs.vh"
module loop_ctrl_props (
  input wire        sys_clk,
  input wire        rst,
  input wire        clk_en,
  input wire [11:0] avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [2:0]  zero_res_sel,
  input wire        zero_res_ext,
  input wire [7:0]  pump_current,
  input wire [1:0]  fb_a_count,
  input wire [5:0]  fb_b_count,
  input wire [7:0]  fb_ratio,
  input wire        lock_det_pd,
  input wire        ref_doubler_en,
  input wire [1:0]  abl_width,
  input wire [1:0]  pump_mode
);
  // ----------
  // helpers
  // ----------
  wire acc = avs_write & ~avs_waitrequest & avs_byteenable[0] & clk_en;
  wire ctl = acc & (avs_address[11:2] == `LOOP_CTRL_IDX);
  // override state is internal, so shadow it from accepted writes
  reg  ovr_r;
  always @(posedge sys_clk)
    if (rst) ovr_r <= 1'h0;
    else if (ctl) ovr_r <= avs_writedata[4];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------
  // properties
  // ----------
  a_wait_first: assert property ($rose(avs_read | avs_write) |-> avs_waitrequest)
    else $error("no wait cycle");
  a_wait_one: assert property ((avs_read | avs_write) && avs_waitrequest && clk_en
    |=> !avs_waitrequest) else $error("wait too long");
  a_zr_ext: assert property (zero_res_ext == (zero_res_sel == `ZR_SEL_EXT))
    else $error("external select mismatch");
  a_pump_load: assert property (acc && avs_address[11:2] == `PUMP_CUR_IDX ##1 clk_en
    |=> pump_current == $past(avs_writedata[7:0], 2)) else $error("pump current");
  a_fb_ratio: assert property (fb_ratio == {fb_b_count, 2'h0} + fb_a_count)
    else $error("divide ratio");
  a_ctl_load: assert property (ctl ##1 clk_en |=> {lock_det_pd, ref_doubler_en, pump_mode}
    == {$past(avs_writedata[7], 2), $past(avs_writedata[5], 2), $past(avs_writedata[1:0], 2)})
    else $error("control outputs");
  a_abl_auto: assert property (ctl && !avs_writedata[4] ##1 clk_en
    |=> abl_width == `ABL_HIGH) else $error("auto width");
  a_abl_clear: assert property (ctl && !ovr_r && avs_writedata[4] ##1 clk_en
    |=> abl_width == `ABL_MIN) else $error("width not cleared");
  a_abl_sel: assert property (ctl && ovr_r && avs_writedata[4] ##1 clk_en
    |=> abl_width == $past(avs_writedata[3:2], 2)) else $error("width select");
  a_rst_dflt: assert property ($fell(rst) |-> pump_mode == `CP_NORMAL && abl_width == `ABL_HIGH)
    else $error("reset defaults");
  a_rd_upper: assert property (avs_readdata[31:8] == `ZERO24)
    else $error("upper read bits");
  c_ovr: cover property (ctl && avs_writedata[4]);
  c_ext: cover property (zero_res_ext);
  c_ratio: cover property (fb_ratio == 8'hff);
endmodule // loop_ctrl_props

// file: testbench/testbench.sv
// self-checking bench for the loop control register bank
// drives the avalon slave directly; clk_en held high except during the frozen-bank write
`timescale 1ns/10ps
`include "loop_ctrl_defs.vh"
module testbench;
  reg         sys_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, avs_read = 1'h0, avs_write = 1'h0;
  reg  [11:0] avs_address = 12'h000;
  reg  [31:0] avs_writedata = 32'h0, rdv;
  reg  [3:0]  avs_byteenable = 4'hf;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, zero_res_ext, lock_det_pd, ref_doubler_en;
  wire [2:0]  zero_res_sel;
  wire [7:0]  pump_current, fb_ratio;
  wire [1:0]  fb_a_count, abl_width, pump_mode;
  wire [5:0]  fb_b_count;
  integer     bad_count = 0, total_checks = 0, i;
  localparam [11:0] ZR = {`ZERO_RES_IDX, 2'h0}, PC = {`PUMP_CUR_IDX, 2'h0};
  localparam [11:0] FB = {`FB_DIV_IDX, 2'h0}, CT = {`LOOP_CTRL_IDX, 2'h0};
  // write, readback, {lock, doubler, width, mode}
  reg  [23:0] tab [0:5] = '{24'ha0a038, 24'h1d1101, 24'h1e1e0e, 24'h171707, 24'h1b1b0b, 24'h0c0c08};
  pll_loop_control_registers i_dut (.sys_clk, .rst, .clk_en, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .zero_res_sel, .zero_res_ext, .pump_current, .fb_a_count, .fb_b_count, .fb_ratio,
    .lock_det_pd, .ref_doubler_en, .abl_width, .pump_mode);
  initial forever #10 sys_clk = ~sys_clk;
  // ----------
  // tasks
  // ----------
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // two idle edges after release let the loop outputs settle
  task req(input [11:0] a, input [31:0] d, input [3:0] be, input w);
    begin
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
      rdv = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    begin
      req(a, 32'h0, 4'hf, 1'h0);
      chk(rdv, exp);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    rd(ZR, 32'h0);
    rd(PC, 32'h0);
    rd(FB, 32'h0);
    rd(CT, 32'h3);
    chk({lock_det_pd, ref_doubler_en, abl_width, pump_mode}, 32'hb);
    for (i = 0; i < 9; i = i + 1) begin
      req(ZR, 32'hf0 | i, 4'hf, 1'h1);
      chk({zero_res_ext, zero_res_sel}, i == 8 ? 4'hd : (i > 3 ? 4'h4 : i));
      rd(ZR, i);
    end
    req(PC, 32'hffffffa5, 4'hf, 1'h1);
    chk(pump_current, 32'ha5);
    req(PC, 32'h11, 4'he, 1'h1);
    rd(PC, 32'ha5);
    // frozen bank: the write waits until clk_en returns
    clk_en <= 1'h0;
    fork
      req(PC, 32'h3c, 4'hf, 1'h1);
      begin
        repeat (4) @(posedge sys_clk);
        chk(avs_waitrequest, 32'h1);
        chk(pump_current, 32'ha5);
        clk_en <= 1'h1;
      end
    join
    chk(pump_current, 32'h3c);
    req(12'h000, 32'hff, 4'hf, 1'h1);
    rd(12'h000, 32'h0);
    req(FB, 32'hff, 4'hf, 1'h1);
    chk({fb_a_count, fb_b_count, fb_ratio}, 32'hffff);
    req(FB, 32'h51, 4'hf, 1'h1);
    chk({fb_a_count, fb_b_count, fb_ratio}, 32'h5145);
    for (i = 0; i < 6; i = i + 1) begin
      req(CT, tab[i][23:16], 4'hf, 1'h1);
      chk({lock_det_pd, ref_doubler_en, abl_width, pump_mode}, tab[i][5:0]);
      rd(CT, tab[i][15:8]);
    end
    // second reset in mid-run brings the defaults back
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    rd(CT, 32'h3);
    chk({lock_det_pd, ref_doubler_en, abl_width, pump_mode}, 32'hb);
    chk(pump_current, 32'h0);
    report_and_stop;
  end
endmodule // testbench
bind pll_loop_control_registers loop_ctrl_props i_props (.sys_clk, .rst, .clk_en, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .zero_res_sel, .zero_res_ext, .pump_current, .fb_a_count, .fb_b_count, .fb_ratio,
  .lock_det_pd, .ref_doubler_en, .abl_width, .pump_mode);
